/* File: hw/mgen_top.sv */
// Caller-ID FSK, tone cadence interrupts and pulse-metering generator
//
// Summary of operation
// RL1: Tone timers raise on/off transition interrupts
// RL2: Separate enable per tone timer interrupt
// RL3: Four tone pending bits in first vector
// RL4: FSK continuous phase, oscillator one only
// RL5: Caller-ID payload written one byte
// RL6: Byte double buffered; request on start
// RL7: Framing zero: start, eight data, stop
// RL8: Framing one: eight raw bits only
// RL9: Active timer sets bit period; per-byte requests
// RL10: FSK timer counts 41.66 us units
// RL11: Mark/space coefficients from bits 15:3
// RL12: Rise and fall transition coefficients used
// RL13: Metering resonator computes at 64 kHz
// RL14: Metering sine multiplied by volume
// RL15: Volume ramps up at 8 kHz to 7FFF
// RL16: Ramp halts when transmit exceeds threshold
// RL17: Off: volume ramps down to zero
// RL18: Metering timers 16 bits, 125 us steps
// RL19: Metering timer interrupt enables and pending
// RL20: Metering control bits plus present status
// RL21: AGC threshold and ramp are 16 bits
// RL22: Cadence counter alternates active and inactive
// RL23: Tone periods in 125 us steps
// RL24: Software computes FSK coefficients at 24 kHz
// RL25: Pending sticky, enables gate interrupt only
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module mgen_top #(
  parameter int unsigned TONE_STEP_CYC = mgen_pkg::TONE_STEP_CYC,
  parameter int unsigned FSK_STEP_CYC = mgen_pkg::FSK_STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] tx_sample,
  output logic irq,
  output logic [1:0] tone_osc_en,
  output logic [15:0] osc1_freq_coeff,
  output logic [15:0] osc1_ampl_coeff,
  output logic fsk_bit_out,
  output logic [15:0] meter_sample
);
  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Dividers are 14 and 13 bits wide; larger steps would be truncated and match early
  if (TONE_STEP_CYC < 2 || FSK_STEP_CYC < 2 ||
      TONE_STEP_CYC > 16384 || FSK_STEP_CYC > 8192) begin : g_bad_step
    $error("Step counts must fit their dividers and be at least two cycles");
  end

  // Keep only coefficient bits 15:3
  function automatic logic [15:0] coef(input logic [15:0] v);
    coef = {v[15:mgen_pkg::COEF_LSB], 3'h0}; // [RL11]
  endfunction : coef

  // ----------------------------------------------------------------
  // Time bases
  // ----------------------------------------------------------------
  logic [13:0] t8_cnt_reg;   // 125 us divider
  logic [12:0] t24_cnt_reg;  // 41.66 us divider
  logic [10:0] t64_cnt_reg;  // 64 kHz divider
  logic tick8;
  logic tick24;
  logic tick64;
  assign tick8 = (t8_cnt_reg == 14'(TONE_STEP_CYC - 1));
  assign tick24 = (t24_cnt_reg == 13'(FSK_STEP_CYC - 1));
  assign tick64 = (t64_cnt_reg == 11'(mgen_pkg::METER_SAMP_CYC - 1));

  // Free-running dividers; all three restart together at reset
  always_ff @(posedge clk) begin
    if (sys_rst || tick8) begin
      t8_cnt_reg <= 14'h0000;
    end else begin
      t8_cnt_reg <= t8_cnt_reg + 14'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || tick24) begin
      t24_cnt_reg <= 13'h0000; // [RL10]
    end else begin
      t24_cnt_reg <= t24_cnt_reg + 13'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst || tick64) begin
      t64_cnt_reg <= 11'h000; // [RL13]
    end else begin
      t64_cnt_reg <= t64_cnt_reg + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------
  logic wait_reg;           // Waitrequest, low one cycle per access
  logic [31:0] rdata_reg;   // Read data, loaded as wait drops
  logic [31:0] rd_mux;
  logic acc;                // Access seen, not yet answered
  logic wr_fire;            // Write takes effect this edge
  logic [4:0] pidx;         // Parameter word index
  logic par_hit;
  assign acc = (avs_read || avs_write) && wait_reg;
  assign wr_fire = avs_write && !wait_reg;
  assign pidx = 5'((avs_address - mgen_pkg::A_PAR_BASE) >> 2);
  assign par_hit = (avs_address >= mgen_pkg::A_PAR_BASE) &&
                   (pidx < 5'(mgen_pkg::PAR_N)) && (avs_address[1:0] == 2'h0);

  // One wait cycle, then one ready cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !acc;
    end
  end
  // Read data captured with the ready cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (acc && avs_read) begin
      rdata_reg <= rd_mux;
    end
  end
  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  logic [15:0] par_reg [mgen_pkg::PAR_N]; // Coefficients and timers
  logic [1:0] fsk_cfg_reg;                // Raw framing, FSK enable
  logic [mgen_pkg::IRQ_N-1:0] irq_en_reg; // irq_enable_first

  // Sixteen-bit words, upper bits ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < mgen_pkg::PAR_N; i++) begin
        par_reg[i] <= 16'h0000;
      end
    end else if (wr_fire && par_hit) begin
      par_reg[pidx] <= avs_writedata[15:0]; // [RL21]
    end
  end
  // Framing defaults to start/stop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fsk_cfg_reg <= 2'h0; // [RL7]
    end else if (wr_fire && avs_address == mgen_pkg::A_FSK_CFG) begin
      fsk_cfg_reg <= avs_writedata[1:0];
    end
  end
  // One enable per interrupt source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_en_reg <= '0;
    end else if (wr_fire && avs_address == mgen_pkg::A_IRQ_EN) begin
      irq_en_reg <= avs_writedata[mgen_pkg::IRQ_N-1:0]; // [RL2] [RL19]
    end
  end

  // ----------------------------------------------------------------
  // Cadence engines: tone 1, tone 2, metering
  // ----------------------------------------------------------------
  logic [2:0] en_w;     // Oscillator enable per channel
  logic [2:0] meter_active_timer_en_w;
  logic [2:0] meter_inactive_timer_en_w;
  logic [5:0] cad_ev;   // {inactive, active} expiry pulses
  for (genvar g = 0; g < 3; g++) begin : g_cad
    localparam int TA = (g == 0) ? mgen_pkg::P_OSC1_TA :
                        (g == 1) ? mgen_pkg::P_T2_TA : mgen_pkg::P_M_TA;
    localparam int TI = (g == 0) ? mgen_pkg::P_T1_TI :
                        (g == 1) ? mgen_pkg::P_T2_TI : mgen_pkg::P_M_TI;
    localparam logic [6:0] OFF = (g == 2) ? mgen_pkg::A_METER_CTRL :
                                            mgen_pkg::A_TONE_CTRL;
    localparam int SH = (g == 2) ? 0 : g * mgen_pkg::TONE_STRIDE;
    logic en_reg;
    logic meter_active_timer_en_reg;
    logic meter_inactive_timer_en_reg;
    logic [15:0] cnt_reg;   // Shared active/inactive counter
    logic [1:0] ev_reg;
    logic hit;
    assign hit = wr_fire && (avs_address == OFF);
    // Counter alternates between active and inactive limits
    always_ff @(posedge clk) begin
      ev_reg <= 2'h0;
      if (sys_rst) begin
        en_reg <= 1'b0;
        meter_active_timer_en_reg <= 1'b0;
        meter_inactive_timer_en_reg <= 1'b0;
        cnt_reg <= 16'h0000;
        ev_reg <= 2'h0;
      end else if (hit) begin
        en_reg <= avs_writedata[SH + mgen_pkg::CB_EN]; // [RL20]
        meter_active_timer_en_reg <= avs_writedata[SH + mgen_pkg::CB_METER_ACTIVE_TIMER_EN];
        meter_inactive_timer_en_reg <= avs_writedata[SH + mgen_pkg::CB_METER_INACTIVE_TIMER_EN];
        cnt_reg <= 16'h0000;
      end else if (tick8) begin
        if (en_reg && meter_active_timer_en_reg) begin
          // Active phase ends: oscillator off
          if (cnt_reg >= par_reg[TA]) begin
            en_reg <= 1'b0; // [RL22] [RL23] [RL18]
            cnt_reg <= 16'h0000;
            ev_reg[0] <= 1'b1; // [RL1]
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end else if (!en_reg && meter_inactive_timer_en_reg) begin
          // Inactive phase ends: oscillator on
          if (cnt_reg >= par_reg[TI]) begin
            en_reg <= 1'b1; // [RL22]
            cnt_reg <= 16'h0000;
            ev_reg[1] <= 1'b1; // [RL1]
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
      end
    end
    assign en_w[g] = en_reg;
    assign meter_active_timer_en_w[g] = meter_active_timer_en_reg;
    assign meter_inactive_timer_en_w[g] = meter_inactive_timer_en_reg;
    assign cad_ev[2*g +: 2] = ev_reg;
    a_cad_active_off: assert property (@(posedge clk) disable iff (sys_rst) // [RL22]
      ev_reg[0] |-> !en_reg && cnt_reg == 16'h0000)
      else $error("Active expiry did not stop oscillator");
  end

  // Tone oscillator enables leave from flops
  assign tone_osc_en = en_w[1:0];

  // ----------------------------------------------------------------
  // FSK engine on oscillator 1
  // ----------------------------------------------------------------
  mgen_pkg::mgen_fsk_st_t fsk_st_reg;
  logic [7:0] hold_reg;      // Second buffer stage
  logic hold_vld_reg;
  logic [9:0] shift_reg;     // Frame, LSB first
  logic [3:0] left_reg;      // Bits still to send
  logic [15:0] bit_tmr_reg;  // Steps into current bit
  logic req_reg;             // Byte request pulse
  logic load;
  logic bit_end;
  logic cur_bit;
  logic prev_bit_reg;
  logic [1:0] trans_reg;     // Transition samples remaining
  logic fwr;
  assign fwr = wr_fire && (avs_address == mgen_pkg::A_FSK_BYTE);
  assign load = (fsk_st_reg == mgen_pkg::FSK_IDLE) && hold_vld_reg &&
                fsk_cfg_reg[mgen_pkg::FB_ENABLE];
  assign bit_end = tick24 && (bit_tmr_reg + 16'h0001 >=
                   par_reg[mgen_pkg::P_OSC1_TA]); // [RL9] [RL10]
  // Idle line sits at mark
  assign cur_bit = (fsk_st_reg == mgen_pkg::FSK_SEND) ? shift_reg[0] : 1'b1;

  // Holding buffer; a new write wins over the take
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_reg <= 8'h00;
      hold_vld_reg <= 1'b0;
    end else if (fwr) begin
      hold_reg <= avs_writedata[7:0]; // [RL5]
      hold_vld_reg <= 1'b1; // [RL6]
    end else if (load) begin
      hold_vld_reg <= 1'b0;
    end
  end

  // Serializer
  always_ff @(posedge clk) begin
    req_reg <= 1'b0;
    if (sys_rst) begin
      fsk_st_reg <= mgen_pkg::FSK_IDLE;
      shift_reg <= 10'h3FF;
      left_reg <= 4'h0;
      bit_tmr_reg <= 16'h0000;
      req_reg <= 1'b0;
    end else begin
      case (fsk_st_reg)
        mgen_pkg::FSK_IDLE: begin
          if (load) begin
            req_reg <= 1'b1; // [RL6]
            bit_tmr_reg <= 16'h0000;
            fsk_st_reg <= mgen_pkg::FSK_SEND;
            if (fsk_cfg_reg[mgen_pkg::FB_RAW]) begin
              shift_reg <= {2'h3, hold_reg}; // [RL8]
              left_reg <= mgen_pkg::LEN_RAW;
            end else begin
              shift_reg <= {1'b1, hold_reg, 1'b0}; // [RL7]
              left_reg <= mgen_pkg::LEN_FRAMED;
            end
          end
        end
        mgen_pkg::FSK_SEND: begin
          if (bit_end) begin
            bit_tmr_reg <= 16'h0000;
            shift_reg <= {1'b1, shift_reg[9:1]};
            left_reg <= left_reg - 4'h1;
            if (left_reg == 4'h1) begin
              fsk_st_reg <= mgen_pkg::FSK_IDLE;
            end
          end else if (tick24) begin
            bit_tmr_reg <= bit_tmr_reg + 16'h0001;
          end
        end
        default: begin
          fsk_st_reg <= mgen_pkg::FSK_IDLE;
        end
      endcase
    end
  end

  // Two transition samples follow each bit change
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_bit_reg <= 1'b1;
      trans_reg <= 2'h0;
    end else begin
      prev_bit_reg <= cur_bit;
      if (cur_bit != prev_bit_reg) begin
        trans_reg <= 2'h2; // [RL12]
      end else if (tick24 && trans_reg != 2'h0) begin
        trans_reg <= trans_reg - 2'h1;
      end
    end
  end

  // Coefficients steer oscillator 1 only; its phase stays continuous
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc1_freq_coeff <= 16'h0000;
      osc1_ampl_coeff <= 16'h0000;
      fsk_bit_out <= 1'b1;
    end else begin
      fsk_bit_out <= cur_bit; // [RL4]
      osc1_ampl_coeff <= coef(par_reg[cur_bit ? mgen_pkg::P_MARK_A :
                                      mgen_pkg::P_SPACE_A]); // [RL11]
      if (trans_reg == 2'h2) begin
        osc1_freq_coeff <= coef(par_reg[cur_bit ? mgen_pkg::P_RISE_HI :
                                        mgen_pkg::P_FALL_HI]); // [RL12]
      end else if (trans_reg == 2'h1) begin
        osc1_freq_coeff <= coef(par_reg[cur_bit ? mgen_pkg::P_RISE_LO :
                                        mgen_pkg::P_FALL_LO]);
      end else begin
        osc1_freq_coeff <= coef(par_reg[cur_bit ? mgen_pkg::P_MARK_F :
                                        mgen_pkg::P_SPACE_F]); // [RL11]
      end
    end
  end

  // Framing is judged as it stood at the load edge, not one cycle later
  a_fsk_frame_len: assert property (@(posedge clk) disable iff (sys_rst) // [RL7] [RL8]
    load |=> left_reg == ($past(fsk_cfg_reg[mgen_pkg::FB_RAW]) ?
                          mgen_pkg::LEN_RAW : mgen_pkg::LEN_FRAMED))
    else $error("Wrong frame length at byte start");
  a_fsk_start_bit: assert property (@(posedge clk) disable iff (sys_rst) // [RL7]
    load && !fsk_cfg_reg[mgen_pkg::FB_RAW] |=> ##1 fsk_bit_out == 1'b0)
    else $error("Framed byte did not begin with start bit");

  // ----------------------------------------------------------------
  // Metering envelope and resonator
  // ----------------------------------------------------------------
  logic [15:0] vol_reg;            // Envelope, 0 to 7FFF
  logic signed [15:0] y1_reg;
  logic signed [15:0] y2_reg;
  logic signed [31:0] rprod;
  logic signed [15:0] ynew;
  logic signed [31:0] mprod;
  logic [15:0] tx_abs;
  logic clip;
  logic [16:0] vol_up;
  logic meter_on;
  assign meter_on = en_w[2];
  assign tx_abs = tx_sample[15] ? 16'(-tx_sample) : tx_sample;
  assign clip = tx_abs > par_reg[mgen_pkg::P_M_AGC]; // [RL16]
  assign vol_up = {1'b0, vol_reg} + {1'b0, par_reg[mgen_pkg::P_M_RAMP]};
  assign rprod = $signed(coef(par_reg[mgen_pkg::P_M_FREQ])) * y1_reg;
  assign ynew = 16'(rprod[28:13] - y2_reg);
  assign mprod = y1_reg * $signed({1'b0, vol_reg[14:0]});

  // Attack, AGC hold and decay at 8 kHz
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vol_reg <= 16'h0000;
    end else if (tick8) begin
      if (meter_on) begin
        if (!clip) begin
          // Saturate at ceiling
          vol_reg <= (vol_up > {1'b0, mgen_pkg::VOL_MAX}) ?
                     mgen_pkg::VOL_MAX : vol_up[15:0]; // [RL15]
        end
      end else if (vol_reg > par_reg[mgen_pkg::P_M_RAMP]) begin
        vol_reg <= vol_reg - par_reg[mgen_pkg::P_M_RAMP]; // [RL17]
      end else begin
        vol_reg <= 16'h0000; // [RL17]
      end
    end
  end

  // Resonator reloads from amplitude while silent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      y1_reg <= 16'sh0000;
      y2_reg <= 16'sh0000;
      meter_sample <= 16'h0000;
    end else if (!meter_on && vol_reg == 16'h0000) begin
      y1_reg <= $signed(par_reg[mgen_pkg::P_M_AMPL]);
      y2_reg <= 16'sh0000;
      meter_sample <= 16'h0000;
    end else if (tick64) begin
      y2_reg <= y1_reg; // [RL13]
      y1_reg <= ynew;
      meter_sample <= 16'(mprod[30:15]); // [RL14]
    end
  end

  a_vol_ceiling: assert property (@(posedge clk) disable iff (sys_rst) // [RL15]
    vol_reg <= mgen_pkg::VOL_MAX)
    else $error("Volume above ceiling");
  a_vol_agc_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RL16]
    tick8 && meter_on && clip |=> $stable(vol_reg))
    else $error("Volume moved while clipping");
  a_vol_decay: assert property (@(posedge clk) disable iff (sys_rst) // [RL17]
    tick8 && !meter_on && vol_reg != 16'h0000 |=>
    vol_reg < $past(vol_reg) || par_reg[mgen_pkg::P_M_RAMP] == 16'h0000)
    else $error("Volume did not ramp down");

  // ----------------------------------------------------------------
  // Interrupt vector and output
  // ----------------------------------------------------------------
  logic [mgen_pkg::IRQ_N-1:0] irq_vec_reg;  // irq_vector_first
  logic [mgen_pkg::IRQ_N-1:0] irq_set;
  logic [mgen_pkg::IRQ_N-1:0] irq_clr;
  logic irq_reg;
  assign irq_set = {req_reg, cad_ev};
  assign irq_clr = (wr_fire && avs_address == mgen_pkg::A_IRQ_VEC) ?
                   avs_writedata[mgen_pkg::IRQ_N-1:0] : '0;

  // Write one to clear; a same-cycle event wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_vec_reg <= '0;
    end else begin
      irq_vec_reg <= (irq_vec_reg & ~irq_clr) | irq_set; // [RL3] [RL19] [RL25]
    end
  end
  // Only enabled pending bits reach the pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_vec_reg & irq_en_reg); // [RL2] [RL25]
    end
  end
  assign irq = irq_reg;

  a_irq_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RL25]
    ##1 irq == |($past(irq_vec_reg) & $past(irq_en_reg)))
    else $error("Interrupt not gated by enables");
  a_pend_sticky: assert property (@(posedge clk) disable iff (sys_rst) // [RL25]
    ##1 (($past(irq_vec_reg) & ~$past(irq_clr)) & ~irq_vec_reg) == '0)
    else $error("Pending bit lost without clear");
  a_fsk_request: assert property (@(posedge clk) disable iff (sys_rst) // [RL6]
    load |=> ##1 irq_vec_reg[mgen_pkg::IRQ_FSK])
    else $error("No byte request at byte start");
  a_wait_single: assert property (@(posedge clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than a cycle");

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      mgen_pkg::A_TONE_CTRL: begin
        rd_mux[2:0] = {meter_inactive_timer_en_w[0], meter_active_timer_en_w[0], en_w[0]};
        rd_mux[6:4] = {meter_inactive_timer_en_w[1], meter_active_timer_en_w[1], en_w[1]};
      end
      mgen_pkg::A_METER_CTRL: begin
        rd_mux[2:0] = {meter_inactive_timer_en_w[2], meter_active_timer_en_w[2], en_w[2]};
        rd_mux[mgen_pkg::CB_PRESENT] = (vol_reg != 16'h0000); // [RL20]
      end
      mgen_pkg::A_IRQ_EN: begin
        rd_mux[mgen_pkg::IRQ_N-1:0] = irq_en_reg;
      end
      mgen_pkg::A_IRQ_VEC: begin
        rd_mux[mgen_pkg::IRQ_N-1:0] = irq_vec_reg; // [RL3]
      end
      mgen_pkg::A_FSK_CFG: begin
        rd_mux[1:0] = fsk_cfg_reg;
      end
      default: begin
        if (par_hit) begin
          rd_mux[15:0] = par_reg[pidx];
        end
      end
    endcase
  end
endmodule : mgen_top
`default_nettype wire

/* File: hw/mgen_pkg.sv */
// Shared constants for the caller-ID and metering signal generator
package mgen_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;      // 100 MHz clock
  localparam int unsigned TONE_STEP_NS = 125000;   // 125 us cadence step
  localparam int unsigned FSK_STEP_NS = 41660;     // 41.66 us FSK step
  localparam int unsigned METER_SAMP_NS = 15625;   // 64 kHz sample
  // Periods round down to whole cycles
  localparam int unsigned TONE_STEP_CYC = TONE_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned FSK_STEP_CYC = FSK_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned METER_SAMP_CYC = METER_SAMP_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] A_TONE_CTRL = 7'h00;
  localparam logic [6:0] A_IRQ_EN = 7'h04;
  localparam logic [6:0] A_IRQ_VEC = 7'h08;
  localparam logic [6:0] A_FSK_BYTE = 7'h0C;
  localparam logic [6:0] A_FSK_CFG = 7'h10;
  localparam logic [6:0] A_METER_CTRL = 7'h14;
  localparam logic [6:0] A_PAR_BASE = 7'h20;
  // Parameter word indices from A_PAR_BASE
  localparam int P_SPACE_F = 0;
  localparam int P_MARK_F = 1;
  localparam int P_SPACE_A = 2;
  localparam int P_MARK_A = 3;
  localparam int P_RISE_HI = 4;
  localparam int P_RISE_LO = 5;
  localparam int P_FALL_HI = 6;
  localparam int P_FALL_LO = 7;
  localparam int P_OSC1_TA = 8;
  localparam int P_M_FREQ = 9;
  localparam int P_M_AMPL = 10;
  localparam int P_M_RAMP = 11;
  localparam int P_M_AGC = 12;
  localparam int P_T1_TI = 13;
  localparam int P_T2_TA = 14;
  localparam int P_T2_TI = 15;
  localparam int P_M_TA = 16;
  localparam int P_M_TI = 17;
  localparam int PAR_N = 18;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int CB_EN = 0;           // Oscillator / metering enable
  localparam int CB_METER_ACTIVE_TIMER_EN = 1;         // Active timer enable
  localparam int CB_METER_INACTIVE_TIMER_EN = 2;         // Inactive timer enable
  localparam int CB_PRESENT = 3;      // Metering waveform present (RO)
  localparam int TONE_STRIDE = 4;     // Bits per tone in tone control
  localparam int FB_RAW = 0;          // Raw 8-bit framing select
  localparam int FB_ENABLE = 1;       // FSK engine enable
  localparam int IRQ_FSK = 6;         // Byte request pending bit
  localparam int IRQ_N = 7;
  localparam int COEF_LSB = 3;        // Coefficients use [15:3]
  localparam logic [15:0] VOL_MAX = 16'h7FFF;
  localparam logic [3:0] LEN_FRAMED = 4'hA;
  localparam logic [3:0] LEN_RAW = 4'h8;
  typedef enum logic [0:0] {FSK_IDLE, FSK_SEND} mgen_fsk_st_t;
endpackage : mgen_pkg

/* File: bench/testbench.sv */
// Self-checking bench for the caller-ID and metering generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, rd_s;
  logic avs_waitrequest, irq, fsk_bit_out, wt_s, fb_prev;
  logic [15:0] tx_sample = 16'h0, osc1_freq_coeff, osc1_ampl_coeff, meter_sample, v;
  logic [1:0] tone_osc_en;
  logic [7:0] b;
  int mismatches = 0, total_checks = 0, falls = 0, seed = 32'h07f5, k;
  always #5 clk = ~clk;
  // Settled values before each rising edge, so the edge never races the bench
  always @(negedge clk) begin
    wt_s = avs_waitrequest;
    rd_s = avs_readdata;
    if (fb_prev === 1'b1 && fsk_bit_out === 1'b0) falls++;
    fb_prev = fsk_bit_out;
  end
  mgen_top #(.TONE_STEP_CYC(20), .FSK_STEP_CYC(12)) dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_sample(tx_sample), .irq(irq),
    .tone_osc_en(tone_osc_en), .osc1_freq_coeff(osc1_freq_coeff),
    .osc1_ampl_coeff(osc1_ampl_coeff), .fsk_bit_out(fsk_bit_out),
    .meter_sample(meter_sample));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One Avalon access; waits for waitrequest low under a bound
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (wt_s !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = rd_s;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) mismatches++;
  endtask : bus
  // Falling line edges of one byte, idle mark on both sides
  function automatic int nfalls(input logic [7:0] d, input logic raw);
    logic [9:0] s;
    logic p;
    int n;
    s = raw ? {2'b11, d} : {1'b1, d, 1'b0};
    p = 1'b1;
    n = 0;
    for (int i = 0; i < 10; i++) begin
      if (p && !s[i]) n++;
      p = s[i];
    end
    return n;
  endfunction : nfalls
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Watchdog sized well above the longest run (about 40k cycles)
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // Parameter words: reset zero, upper half reads zero
    for (k = 0; k < mgen_pkg::PAR_N; k++) begin
      bus(1'b0, mgen_pkg::A_PAR_BASE + 7'(4 * k), 32'h0);
      chk("param reset", q, 32'h0);
      q = $random(seed);
      v = q[15:0];
      bus(1'b1, mgen_pkg::A_PAR_BASE + 7'(4 * k), q);
      bus(1'b0, mgen_pkg::A_PAR_BASE + 7'(4 * k), 32'h0);
      chk("param", q, {16'h0, v});
    end
    bus(1'b0, mgen_pkg::A_FSK_BYTE, 32'h0);
    chk("byte reg", q, 32'h0);
    // Tone two cadence: active event enabled, inactive far away
    bus(1'b1, 7'h58, 32'h3);
    bus(1'b1, 7'h5C, 32'hFFFF);
    bus(1'b1, mgen_pkg::A_IRQ_EN, 32'h4);
    bus(1'b1, mgen_pkg::A_IRQ_VEC, 32'h7F);
    // Metering cadence alongside: active expiry on the third step
    bus(1'b1, 7'h60, 32'h2);
    bus(1'b1, mgen_pkg::A_METER_CTRL, 32'h3);
    bus(1'b1, mgen_pkg::A_TONE_CTRL, 32'h70);
    repeat (200) @(posedge clk);
    bus(1'b0, mgen_pkg::A_IRQ_VEC, 32'h0);
    chk("vector", q, 32'h14);
    chk("osc en", {30'h0, tone_osc_en}, 32'h0);
    chk("irq on", {31'h0, irq}, 32'h1);
    bus(1'b1, mgen_pkg::A_IRQ_EN, 32'h8);
    bus(1'b0, mgen_pkg::A_IRQ_VEC, 32'h0);
    chk("irq gated", {31'h0, irq}, 32'h0);
    bus(1'b1, mgen_pkg::A_IRQ_VEC, 32'h14);
    bus(1'b0, mgen_pkg::A_IRQ_VEC, 32'h0);
    chk("vector clr", q, 32'h0);
    bus(1'b1, mgen_pkg::A_TONE_CTRL, 32'h0);
    // FSK bytes, framed then raw, random data and mark coefficient
    bus(1'b1, 7'h40, 32'h1);
    for (k = 0; k < 2; k++) begin
      b = $random(seed);
      v = $random(seed);
      bus(1'b1, 7'h24, {16'h0, v});
      bus(1'b1, 7'h2C, {16'h0, ~v});
      bus(1'b1, mgen_pkg::A_FSK_CFG, 32'(2 + k));
      bus(1'b1, mgen_pkg::A_IRQ_VEC, 32'h7F);
      falls = 0;
      bus(1'b1, mgen_pkg::A_FSK_BYTE, {24'h0, b});
      repeat (300) @(posedge clk);
      chk("fsk falls", falls, nfalls(b, k[0]));
      bus(1'b0, mgen_pkg::A_IRQ_VEC, 32'h0);
      chk("byte req", q & 32'h40, 32'h40);
      chk("mark coeff", {16'h0, osc1_freq_coeff}, {16'h0, v[15:3], 3'b0});
      chk("mark ampl", {16'h0, osc1_ampl_coeff}, {16'h0, ~v[15:3], 3'b0});
    end
    // Metering envelope: clipped, ramped, decayed
    bus(1'b1, 7'h4C, 32'h7FFF);
    bus(1'b1, 7'h50, 32'h0);
    tx_sample <= 16'($random(seed)) | 16'h1;
    bus(1'b1, mgen_pkg::A_METER_CTRL, 32'h1);
    repeat (13000) @(posedge clk);
    bus(1'b0, mgen_pkg::A_METER_CTRL, 32'h0);
    chk("meter clip", q, 32'h1);
    bus(1'b1, 7'h50, 32'h7FFF);
    tx_sample <= 16'h0;
    repeat (13000) @(posedge clk);
    bus(1'b0, mgen_pkg::A_METER_CTRL, 32'h0);
    chk("meter up", q, 32'h9);
    bus(1'b1, mgen_pkg::A_METER_CTRL, 32'h0);
    repeat (13000) @(posedge clk);
    bus(1'b0, mgen_pkg::A_METER_CTRL, 32'h0);
    chk("meter down", q, 32'h0);
    chk("meter quiet", {16'h0, meter_sample}, 32'h0);
    final_report();
  end
endmodule : testbench
`default_nettype wire
